// ### rtl/ilot_pkg.sv
/*
 Shared constants and types for the input-limit and on/off timing block:
 command codes, field positions, reset values, timing figures, carriers.
 Assumes a single 125 MHz clock and a command front end that presents
 one decoded command per request.
*/
package ilot_pkg;

	// Clock and time base
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned NS_PER_MS = 1000000;
	localparam int unsigned CYC_PER_MS_DFLT = NS_PER_MS / CLK_PERIOD_NS;
	localparam int unsigned PRE_W = 20;
	localparam int unsigned MS_W = 9;
	localparam logic [MS_W-1:0] MS_SAT = 9'h1FF;

	// Timing figures in milliseconds
	localparam logic [MS_W-1:0] RETRY_STEP_MS = 9'h023;
	localparam logic [MS_W-1:0] TON_MIN_MS = 9'h003;
	localparam logic [MS_W-1:0] TON_MAX_MS = 9'h0FA;
	localparam logic [MS_W-1:0] TOFF_MIN_MS = 9'h004;
	localparam logic [MS_W-1:0] TOFF_MAX_MS = 9'h0FA;
	localparam logic [MS_W-1:0] RISE_MAX_MS = 9'h064;
	localparam logic [MS_W-1:0] FALL_MAX_MS = 9'h064;
	localparam logic [MS_W-1:0] ZERO_MS = 9'h000;

	// Command codes
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_OV_WARN = 8'h57;
	localparam logic [7:0] CMD_UV_WARN = 8'h58;
	localparam logic [7:0] CMD_UV_FAULT = 8'h59;
	localparam logic [7:0] CMD_UV_RESP = 8'h5A;
	localparam logic [7:0] CMD_PG_ON = 8'h5E;
	localparam logic [7:0] CMD_TURN_ON_WAIT_TIME = 8'h60;
	localparam logic [7:0] CMD_TURN_ON_RAMP_TIME = 8'h61;
	localparam logic [7:0] CMD_TURN_OFF_WAIT_TIME = 8'h64;
	localparam logic [7:0] CMD_TOFF_FALL = 8'h65;
	localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
	localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
	localparam logic [7:0] CMD_STATUS_INPUT = 8'h7C;

	// Reset values (Linear words, exponent 0, except the 8-bit response byte)
	localparam logic [15:0] RST_OV_WARN = 16'h000E;
	localparam logic [15:0] RST_UV_WARN = 16'h0008;
	localparam logic [15:0] RST_UV_FAULT = 16'h0007;
	localparam logic [7:0] RST_UV_RESP = 8'hC0;
	localparam logic [15:0] RST_PG_ON = 16'h0000;
	localparam logic [15:0] RST_TURN_ON_WAIT_TIME = 16'h001E;
	localparam logic [15:0] RST_TURN_ON_RAMP_TIME = 16'h000A;
	localparam logic [15:0] RST_TURN_OFF_WAIT_TIME = 16'h0004;
	localparam logic [15:0] RST_TOFF_FALL = 16'h000A;

	// Fault response fields
	localparam int unsigned RESP_HI = 7;
	localparam int unsigned RESP_LO = 6;
	localparam int unsigned RCNT_HI = 5;
	localparam int unsigned RCNT_LO = 3;
	localparam int unsigned RTIM_HI = 2;
	localparam int unsigned RTIM_LO = 0;
	localparam logic [1:0] RESP_RETRY = 2'h2;
	localparam logic [1:0] RESP_RESUME = 2'h3;
	localparam logic [2:0] RETRY_NONE = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;

	// Status bit positions
	localparam int unsigned SB_OFF = 6;
	localparam int unsigned SB_UV_FAULT = 3;
	localparam int unsigned SW_INPUT = 13;
	localparam int unsigned SW_PG_BAD = 11;
	localparam int unsigned SI_OV_WARN = 6;
	localparam int unsigned SI_UV_WARN = 5;
	localparam int unsigned SI_UV_FAULT = 4;

	// Linear number format
	localparam int unsigned LIN_FRAC = 8;
	localparam int unsigned Q_W = 24;
	localparam int unsigned NUM_LIN = 8;
	localparam int unsigned LIN_VIN = 0;
	localparam int unsigned LIN_OVW = 1;
	localparam int unsigned LIN_UVW = 2;
	localparam int unsigned LIN_UVF = 3;
	localparam int unsigned LIN_TOND = 4;
	localparam int unsigned LIN_TONR = 5;
	localparam int unsigned LIN_TOFFD = 6;
	localparam int unsigned LIN_TOFFF = 7;

	typedef enum logic [2:0] {
		ST_OFF = 3'h0,
		ST_ON_WAIT = 3'h1,
		ST_RISE = 3'h3,
		ST_ON = 3'h2,
		ST_OFF_WAIT = 3'h6,
		ST_FALL = 3'h7,
		ST_RETRY = 3'h5,
		ST_HOLD = 3'h4
	} ilot_state_t;

	typedef struct packed {
		logic [7:0] cmd;
		logic wr;
		logic rd;
		logic [15:0] wdata;
	} ilot_req_t;

	typedef struct packed {
		logic ack;
		logic nack;
		logic [15:0] rdata;
	} ilot_rsp_t;

	typedef struct packed {
		logic [15:0] ov_warn;
		logic [15:0] uv_warn;
		logic [15:0] uv_fault;
		logic [7:0] uv_resp;
		logic [15:0] pg_on;
		logic [15:0] turn_on_wait_time;
		logic [15:0] turn_on_ramp_time;
		logic [15:0] turn_off_wait_time;
		logic [15:0] toff_fall;
	} ilot_regs_t;

endpackage

// ### rtl/ilot_lin_dec.sv
/*
 Linear number decoder: 5-bit signed exponent, 11-bit signed mantissa,
 to an unsigned fixed-point value with LIN_FRAC fraction bits.
 Assumes negative values are meaningless here and reads them as zero.
*/
`timescale 1ns/1ps
module ilot_lin_dec
	import ilot_pkg::*;
(
	input wire logic [15:0] lin_in,
	output logic [Q_W-1:0] value_out
);

	logic signed [6:0] shift;
	logic [Q_W+15:0] wide;

	always_comb begin
		shift = 7'($signed(lin_in[15:11])) + 7'sd8;
		wide = '0;
		value_out = '0;
		if (lin_in[10]) begin
			value_out = '0;
		end else if (!shift[6]) begin
			wide = (Q_W+16)'(lin_in[10:0]) << shift[5:0];
			value_out = (|wide[Q_W+15:Q_W]) ? '1 : wide[Q_W-1:0];
		end else begin
			value_out = Q_W'(lin_in[10:0] >> 7'(-shift));
		end
	end

endmodule

// ### rtl/ilot_top.sv
/*
 Input limit and on/off timing: threshold registers, input undervoltage
 fault response with retry, turn-on/turn-off sequencing, power good.
 Assumes a command front end that decodes bus transactions into one
 request per cycle, and measured input/output levels synchronous to clk.
*/
`timescale 1ns/1ps

// Functional notes
// - Any undervoltage response pulls alert low and sets the fault bit.
// - Response 10 shuts off at once, then retries per retry count.
// - Response 11 shuts off, restarts when input exceeds the warning level.
// - Restart attempts equal the retry count field.
// - Retry count zero: no restart; output stays off until faults cleared.
// - Retry count seven: retry forever until disabled or other shutdown.
// - Retry interval is (retry time field plus one) times 35 ms.
// - Hold 16-bit Linear undervoltage fault level; below it is a fault.
// - Hold 16-bit Linear undervoltage warning level; also resume level.
// - Hold 16-bit Linear overvoltage warning level for warnings.
// - Power good only when output reaches the 16-bit threshold.
// - After enable wait turn-on delay, 3 to 250 ms, before rising.
// - In a sharing group the delay range binds only bus or pin enables.
// - After the delay ramp up over the rise time, 0 to 100 ms.
// - After disable wait turn-off delay, 4 to 250 ms, before falling.
// - Turn-off delay zero cuts the output at once, no ramp-down.
// - After turn-off delay ramp down over fall time, 0 to 100 ms.
// - Undervoltage fault shows as bit 3 of the summary status byte.
module ilot_top
	import ilot_pkg::*;
#(
	parameter int unsigned CYCLES_PER_MS = CYC_PER_MS_DFLT
)
(
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic ce_in,
	input wire ilot_req_t pmb_req_in,
	output ilot_rsp_t pmb_rsp_out,
	input wire logic enable_in,
	input wire logic group_mode_in,
	input wire logic self_start_in,
	input wire logic [15:0] vin_lin_in,
	input wire logic [15:0] vout_level_in,
	output logic power_stage_on_out,
	output logic ramp_up_out,
	output logic ramp_down_out,
	output logic output_good_flag_out,
	output logic fault_alert_line_n_out
);

	typedef struct packed {
		ilot_state_t st;
		ilot_regs_t regs;
		logic [PRE_W-1:0] pre;
		logic [MS_W-1:0] ms;
		logic [2:0] retries;
		logic uv_flt;
		logic uv_wrn;
		logic ov_wrn;
		logic pg;
		ilot_rsp_t rsp;
	} ilot_core_t;

	ilot_core_t r;
	ilot_core_t next_r;
	logic [15:0] lin_word [NUM_LIN];
	logic [Q_W-1:0] lin_q [NUM_LIN];
	logic [MS_W-1:0] ton_ms, rise_ms, toff_ms, fall_ms, retry_ms;
	logic uv_evt, uv_warn_now, ov_warn_now, resume_ok, tick, clr;
	logic [1:0] resp;
	logic [2:0] rcnt;
	logic [7:0] sbyte;
	logic pg_cause;

	function automatic logic [MS_W-1:0] to_ms(input logic [Q_W-1:0] q,
			input logic [MS_W-1:0] lo, input logic [MS_W-1:0] hi,
			input logic bound);
		logic [15:0] whole;
		whole = q[Q_W-1:LIN_FRAC];
		if (whole > 16'(hi) && bound) begin
			to_ms = hi;
		end else if (whole > 16'(MS_SAT)) begin
			to_ms = MS_SAT;
		end else if (whole < 16'(lo) && bound) begin
			to_ms = lo;
		end else begin
			to_ms = whole[MS_W-1:0];
		end
	endfunction

	always_comb begin
		lin_word[LIN_VIN] = vin_lin_in;
		lin_word[LIN_OVW] = r.regs.ov_warn;
		lin_word[LIN_UVW] = r.regs.uv_warn;
		lin_word[LIN_UVF] = r.regs.uv_fault;
		lin_word[LIN_TOND] = r.regs.turn_on_wait_time;
		lin_word[LIN_TONR] = r.regs.turn_on_ramp_time;
		lin_word[LIN_TOFFD] = r.regs.turn_off_wait_time;
		lin_word[LIN_TOFFF] = r.regs.toff_fall;
	end

	for (genvar i = 0; i < NUM_LIN; i++) begin : g_dec
		ilot_lin_dec u_dec (
			.lin_in(lin_word[i]),
			.value_out(lin_q[i])
		);
	end

	always_comb begin
		resp = r.regs.uv_resp[RESP_HI:RESP_LO];
		rcnt = r.regs.uv_resp[RCNT_HI:RCNT_LO];
		ton_ms = to_ms(lin_q[LIN_TOND], TON_MIN_MS, TON_MAX_MS,
			!(group_mode_in && self_start_in));
		rise_ms = to_ms(lin_q[LIN_TONR], ZERO_MS, RISE_MAX_MS, 1'b1);
		toff_ms = (lin_q[LIN_TOFFD][Q_W-1:LIN_FRAC] == 16'h0000) ? ZERO_MS :
			to_ms(lin_q[LIN_TOFFD], TOFF_MIN_MS, TOFF_MAX_MS, 1'b1);
		fall_ms = to_ms(lin_q[LIN_TOFFF], ZERO_MS, FALL_MAX_MS, 1'b1);
		retry_ms = MS_W'(({6'h00, r.regs.uv_resp[RTIM_HI:RTIM_LO]} + 9'h001)
			* RETRY_STEP_MS);
		uv_evt = enable_in && (lin_q[LIN_VIN] < lin_q[LIN_UVF]);
		uv_warn_now = lin_q[LIN_VIN] < lin_q[LIN_UVW];
		ov_warn_now = lin_q[LIN_VIN] > lin_q[LIN_OVW];
		resume_ok = lin_q[LIN_VIN] > lin_q[LIN_UVW];
		tick = r.pre == PRE_W'(CYCLES_PER_MS - 1);
		clr = pmb_req_in.wr && pmb_req_in.cmd == CMD_CLEAR_FAULTS;
		pg_cause = (r.st == ST_RISE || r.st == ST_ON)
			&& vout_level_in >= r.regs.pg_on;
		sbyte = '0;
		sbyte[SB_OFF] = r.st == ST_OFF;
		sbyte[SB_UV_FAULT] = r.uv_flt;
	end

	always_comb begin
		next_r = r;
		next_r.pre = tick ? '0 : r.pre + PRE_W'(1);
		if (tick && r.ms != MS_SAT) begin
			next_r.ms = r.ms + MS_W'(1);
		end
		unique case (r.st)
			ST_OFF: begin
				next_r.retries = '0;
				if (enable_in) begin
					next_r.st = ST_ON_WAIT;
				end
			end
			ST_ON_WAIT, ST_RISE, ST_ON, ST_OFF_WAIT: begin
				if (uv_evt && resp == RESP_RETRY) begin
					if (rcnt == RETRY_NONE) begin
						next_r.st = ST_HOLD;
					end else if (rcnt != RETRY_FOREVER && r.retries >= rcnt) begin
						next_r.st = ST_HOLD;
					end else begin
						next_r.st = ST_RETRY;
					end
				end else if (uv_evt && resp == RESP_RESUME) begin
					next_r.st = ST_HOLD;
				end else if (r.st == ST_OFF_WAIT) begin
					if (enable_in) begin
						next_r.st = ST_ON;
					end else if (r.ms >= toff_ms) begin
						next_r.st = (fall_ms == ZERO_MS) ? ST_OFF : ST_FALL;
					end
				end else if (!enable_in) begin
					next_r.st = (toff_ms == ZERO_MS) ? ST_OFF : ST_OFF_WAIT;
				end else if (r.st == ST_ON_WAIT && r.ms >= ton_ms) begin
					next_r.st = ST_RISE;
				end else if (r.st == ST_RISE && r.ms >= rise_ms) begin
					next_r.st = ST_ON;
				end
			end
			ST_FALL: begin
				if (r.ms >= fall_ms) begin
					next_r.st = ST_OFF;
				end
			end
			ST_RETRY: begin
				if (!enable_in) begin
					next_r.st = ST_OFF;
				end else if (r.ms >= retry_ms) begin
					next_r.st = ST_ON_WAIT;
					if (rcnt != RETRY_FOREVER) begin
						next_r.retries = r.retries + 3'h1;
					end
				end
			end
			ST_HOLD: begin
				if (!enable_in) begin
					next_r.st = ST_OFF;
				end else if (resp == RESP_RESUME && resume_ok) begin
					next_r.st = ST_ON_WAIT;
				end else if (resp != RESP_RESUME && clr && !uv_evt) begin
					next_r.st = ST_ON_WAIT;
					next_r.retries = '0;
				end
			end
		endcase
		if (next_r.st != r.st) begin
			next_r.pre = '0;
			next_r.ms = '0;
		end
		next_r.uv_flt = uv_evt || (r.uv_flt && !clr);
		next_r.uv_wrn = (enable_in && uv_warn_now) || (r.uv_wrn && !clr);
		next_r.ov_wrn = ov_warn_now || (r.ov_wrn && !clr);
		next_r.pg = pg_cause;
		next_r.rsp = '0;
		next_r.rsp.ack = pmb_req_in.wr || pmb_req_in.rd;
		if (pmb_req_in.wr) begin
			unique case (pmb_req_in.cmd)
				CMD_CLEAR_FAULTS: next_r.rsp.nack = 1'b0;
				CMD_OV_WARN: next_r.regs.ov_warn = pmb_req_in.wdata;
				CMD_UV_WARN: next_r.regs.uv_warn = pmb_req_in.wdata;
				CMD_UV_FAULT: next_r.regs.uv_fault = pmb_req_in.wdata;
				CMD_UV_RESP: next_r.regs.uv_resp = pmb_req_in.wdata[7:0];
				CMD_PG_ON: next_r.regs.pg_on = pmb_req_in.wdata;
				CMD_TURN_ON_WAIT_TIME: next_r.regs.turn_on_wait_time = pmb_req_in.wdata;
				CMD_TURN_ON_RAMP_TIME: next_r.regs.turn_on_ramp_time = pmb_req_in.wdata;
				CMD_TURN_OFF_WAIT_TIME: next_r.regs.turn_off_wait_time = pmb_req_in.wdata;
				CMD_TOFF_FALL: next_r.regs.toff_fall = pmb_req_in.wdata;
				default: next_r.rsp.nack = 1'b1;
			endcase
		end else if (pmb_req_in.rd) begin
			unique case (pmb_req_in.cmd)
				CMD_OV_WARN: next_r.rsp.rdata = r.regs.ov_warn;
				CMD_UV_WARN: next_r.rsp.rdata = r.regs.uv_warn;
				CMD_UV_FAULT: next_r.rsp.rdata = r.regs.uv_fault;
				CMD_UV_RESP: next_r.rsp.rdata = {8'h00, r.regs.uv_resp};
				CMD_PG_ON: next_r.rsp.rdata = r.regs.pg_on;
				CMD_TURN_ON_WAIT_TIME: next_r.rsp.rdata = r.regs.turn_on_wait_time;
				CMD_TURN_ON_RAMP_TIME: next_r.rsp.rdata = r.regs.turn_on_ramp_time;
				CMD_TURN_OFF_WAIT_TIME: next_r.rsp.rdata = r.regs.turn_off_wait_time;
				CMD_TOFF_FALL: next_r.rsp.rdata = r.regs.toff_fall;
				CMD_STATUS_BYTE: next_r.rsp.rdata = {8'h00, sbyte};
				CMD_STATUS_WORD: begin
					next_r.rsp.rdata = {8'h00, sbyte};
					next_r.rsp.rdata[SW_INPUT] = r.uv_flt | r.uv_wrn | r.ov_wrn;
					next_r.rsp.rdata[SW_PG_BAD] = !r.pg;
				end
				CMD_STATUS_INPUT: begin
					next_r.rsp.rdata[SI_OV_WARN] = r.ov_wrn;
					next_r.rsp.rdata[SI_UV_WARN] = r.uv_wrn;
					next_r.rsp.rdata[SI_UV_FAULT] = r.uv_flt;
				end
				default: next_r.rsp.nack = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			r <= '0;
			r.st <= ST_OFF;
			r.regs <= '{RST_OV_WARN, RST_UV_WARN, RST_UV_FAULT, RST_UV_RESP,
				RST_PG_ON, RST_TURN_ON_WAIT_TIME, RST_TURN_ON_RAMP_TIME, RST_TURN_OFF_WAIT_TIME,
				RST_TOFF_FALL};
		end else if (ce_in) begin
			r <= next_r;
		end
	end

	assign pmb_rsp_out = r.rsp;
	assign power_stage_on_out = r.st == ST_RISE || r.st == ST_ON
		|| r.st == ST_OFF_WAIT || r.st == ST_FALL;
	assign ramp_up_out = r.st == ST_RISE;
	assign ramp_down_out = r.st == ST_FALL;
	assign output_good_flag_out = r.pg;
	assign fault_alert_line_n_out = !r.uv_flt;

	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	AST_ALERT_LOW: assert property (
		ce_in && uv_evt |=> !fault_alert_line_n_out)
		else $error("alert line not pulled low on undervoltage");
	AST_STATUS_BIT: assert property (
		ce_in && r.uv_flt && pmb_req_in.rd && !pmb_req_in.wr
		&& pmb_req_in.cmd == CMD_STATUS_BYTE
		|=> pmb_rsp_out.rdata[SB_UV_FAULT] && pmb_rsp_out.ack)
		else $error("status byte bit 3 missing after undervoltage");
	AST_RETRY_SHUT: assert property (
		ce_in && uv_evt && resp == RESP_RETRY && power_stage_on_out
		|=> !power_stage_on_out ##0 (r.st == ST_RETRY || r.st == ST_HOLD))
		else $error("output not cut on undervoltage with retry response");
	AST_RESUME: assert property (
		ce_in && r.st == ST_HOLD && resp == RESP_RESUME && enable_in
		&& resume_ok |=> r.st == ST_ON_WAIT)
		else $error("no resume above warning level");
	AST_RETRY_COUNT: assert property (
		ce_in && r.st == ST_RETRY && next_r.st == ST_ON_WAIT
		&& rcnt != RETRY_FOREVER |=> r.retries == $past(r.retries) + 3'h1)
		else $error("retry attempt not counted");
	AST_NO_RETRY: assert property (
		ce_in && uv_evt && resp == RESP_RETRY && rcnt == RETRY_NONE
		&& r.st != ST_OFF && r.st != ST_FALL && r.st != ST_HOLD
		|=> r.st == ST_HOLD)
		else $error("retry attempted with retry count zero");
	AST_FOREVER: assert property (
		ce_in && r.st == ST_RETRY && rcnt == RETRY_FOREVER && enable_in
		|=> r.st == ST_RETRY || r.st == ST_ON_WAIT)
		else $error("continuous retry stopped while enabled");
	AST_RETRY_GAP: assert property (
		ce_in && r.st == ST_RETRY && enable_in && r.ms < retry_ms
		|=> r.st == ST_RETRY)
		else $error("retry left before its interval");
	AST_ON_DELAY: assert property (
		ce_in && r.st == ST_ON_WAIT && enable_in && !uv_evt && r.ms < ton_ms
		|=> r.st == ST_ON_WAIT && !ramp_up_out)
		else $error("rise began before turn-on delay");
	AST_RISE_DONE: assert property (
		ce_in && r.st == ST_RISE && enable_in && !uv_evt && r.ms >= rise_ms
		|=> r.st == ST_ON ##1 !ramp_up_out)
		else $error("rise did not end at rise time");
	AST_FAST_OFF: assert property (
		ce_in && (r.st == ST_ON || r.st == ST_RISE) && !enable_in && !uv_evt
		&& toff_ms == ZERO_MS |=> !power_stage_on_out && !ramp_down_out)
		else $error("zero turn-off delay did not cut output");
	AST_PG_CAUSE: assert property (
		ce_in && vout_level_in < r.regs.pg_on |=> !output_good_flag_out)
		else $error("power good without reaching its threshold");
	AST_WARN_KEEP: assert property (
		ce_in && r.st == ST_ON && enable_in && uv_warn_now && !uv_evt
		|=> r.uv_wrn && r.st == ST_ON)
		else $error("warning changed output state");

	COV_RETRY: cover property (r.st == ST_RETRY ##1 r.st == ST_ON_WAIT);
	COV_RESUME: cover property (r.st == ST_HOLD ##1 r.st == ST_ON_WAIT);
	COV_SOFT_OFF: cover property (r.st == ST_FALL ##1 r.st == ST_OFF);
	COV_UP: cover property (r.st == ST_RISE ##1 r.st == ST_ON);

endmodule

// ### testbench/ilot_host_model.sv
/*
 Host side model: issues one decoded command per transfer.
 Assumes the block answers one clock after the request edge.
*/
`timescale 1ns/1ps
module ilot_host_model
	import ilot_pkg::*;
(
	input wire logic clk_in,
	input wire ilot_rsp_t rsp_in,
	output ilot_req_t req_out
);
	initial req_out = '{cmd: 8'hA5, wr: 1'b0, rd: 1'b0, wdata: 16'h5A5A};

	// One request pulse, answer taken in the following cycle
	task automatic xfer(input logic w, input logic [7:0] c,
		input logic [15:0] d, output ilot_rsp_t r);
		@(negedge clk_in);
		req_out = '{cmd: c, wr: w, rd: !w, wdata: d};
		@(negedge clk_in);
		r = rsp_in;
		req_out = '{cmd: ~c, wr: 1'b0, rd: 1'b0, wdata: ~d};
	endtask

	// Self-started units get a turn-on delay of at least 30 ms
	task automatic set_ton(input logic [15:0] ms, input logic self);
		ilot_rsp_t r;
		if (self && ms < 16'h001E) begin
			ms = 16'h001E;
		end
		xfer(1'b1, CMD_TURN_ON_WAIT_TIME, ms, r);
	endtask
endmodule

// ### testbench/input_limit_and_onoff_timing_test.sv
/*
 Bench for the input limit and on/off timing block.
 Assumes the host model beside it and a four-cycle millisecond.
*/
`timescale 1ns/1ps
module input_limit_and_onoff_timing_test;
	import ilot_pkg::*;
	localparam int CPM = 4;
	localparam logic [7:0] CM [8] = '{CMD_OV_WARN, CMD_UV_WARN,
		CMD_UV_FAULT, CMD_PG_ON, CMD_TURN_ON_WAIT_TIME, CMD_TURN_ON_RAMP_TIME, CMD_TURN_OFF_WAIT_TIME,
		CMD_TOFF_FALL};
	localparam logic [15:0] RV [8] = '{RST_OV_WARN, RST_UV_WARN,
		RST_UV_FAULT, RST_PG_ON, RST_TURN_ON_WAIT_TIME, RST_TURN_ON_RAMP_TIME, RST_TURN_OFF_WAIT_TIME,
		RST_TOFF_FALL};
	localparam logic [2:0] RC [3] = '{3'h0, 3'h1, 3'h7};
	`define CHK(g, e) begin checked++; if ((g) !== (e)) begin \
		err_total++; $display("wrong value t=%0t got %0h exp %0h", \
		$time, g, e); end end
	int err_total = 0;
	int checked = 0;
	int n;
	int r;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic enable_in = 1'b0;
	logic group_mode_in = 1'b0;
	logic self_start_in = 1'b0;
	logic [15:0] vin_lin_in = 16'h000A;
	logic [15:0] vout_level_in = 16'h0000;
	logic [15:0] d;
	ilot_req_t req;
	ilot_rsp_t rsp;
	logic pso, rup, rdn, pg, alert_n;

	ilot_host_model i_host (.clk_in(clk_in), .rsp_in(rsp), .req_out(req));
	ilot_top #(.CYCLES_PER_MS(CPM)) i_dut (
		.clk_in(clk_in), .reset_in(reset_in), .ce_in(1'b1),
		.pmb_req_in(req), .pmb_rsp_out(rsp), .enable_in(enable_in),
		.group_mode_in(group_mode_in), .self_start_in(self_start_in),
		.vin_lin_in(vin_lin_in), .vout_level_in(vout_level_in),
		.power_stage_on_out(pso), .ramp_up_out(rup),
		.ramp_down_out(rdn), .output_good_flag_out(pg),
		.fault_alert_line_n_out(alert_n)
	);

	initial begin
		forever #4 clk_in = ~clk_in;
	end

	function automatic logic sig(int k);
		case (k)
			0: return pso;
			1: return rup;
			2: return rdn;
			default: return alert_n;
		endcase
	endfunction

	task automatic wait_sig(int k, logic v, int lim);
		n = 0;
		while (sig(k) !== v && n < lim) begin
			@(negedge clk_in);
			n++;
		end
	endtask

	task automatic win(int lo, int hi);
		`CHK(n >= lo && n <= hi, 1'b1)
	endtask

	task automatic acc(logic w, logic [7:0] c, logic [15:0] x, logic nk);
		ilot_rsp_t a;
		i_host.xfer(w, c, x, a);
		`CHK(a.ack, 1'b1)
		`CHK(a.nack, nk)
		if (!w && !nk) `CHK(a.rdata, x)
	endtask

	task automatic go(logic en, logic [15:0] v);
		@(negedge clk_in);
		enable_in = en;
		vin_lin_in = v;
	endtask

	task automatic bring_on();
		go(1'b1, 16'h0009 + 16'($urandom_range(0, 4)));
		wait_sig(0, 1'b1, 1500);
		wait_sig(1, 1'b0, 500);
		`CHK(pso, 1'b1)
	endtask

	task automatic clean();
		go(1'b0, 16'h000A);
		wait_sig(0, 1'b0, 2000);
		`CHK(pso, 1'b0)
		acc(1'b1, CMD_CLEAR_FAULTS, 16'h0000, 1'b0);
		`CHK(alert_n, 1'b1)
	endtask

	task automatic complete_run();
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		#(60000 * 8);
		err_total++;
		complete_run();
	end

	initial begin
		void'($urandom(57115));
		repeat (6) @(negedge clk_in);
		reset_in = 1'b0;
		acc(1'b0, CMD_STATUS_BYTE, 16'h0040, 1'b0);
		acc(1'b0, CMD_UV_RESP, {8'h00, RST_UV_RESP}, 1'b0);
		for (int i = 0; i < 8; i++) begin
			acc(1'b0, CM[i], RV[i], 1'b0);
			d = 16'($urandom);
			acc(1'b1, CM[i], d, 1'b0);
			acc(1'b0, CM[i], d, 1'b0);
			acc(1'b1, CM[i], RV[i], 1'b0);
		end
		acc(1'b0, 8'h42, 16'h0000, 1'b1);
		acc(1'b1, CMD_STATUS_BYTE, 16'h0000, 1'b1);
		i_host.set_ton(16'h0001, 1'b0);
		acc(1'b1, CMD_TURN_ON_RAMP_TIME, 16'h0002, 1'b0);
		acc(1'b1, CMD_TOFF_FALL, 16'h0001, 1'b0);
		for (int g = 0; g < 2; g++) begin
			group_mode_in = g[0];
			go(1'b1, 16'h000A);
			wait_sig(0, 1'b1, 200);
			win(3 * CPM, 3 * CPM + 4);
			`CHK(rup, 1'b1)
			wait_sig(1, 1'b0, 200);
			win(2 * CPM - 1, 2 * CPM + 3);
			d = 16'($urandom_range(256, 65000));
			acc(1'b1, CMD_PG_ON, d, 1'b0);
			vout_level_in = d - 16'h0001;
			repeat (3) @(negedge clk_in);
			`CHK(pg, 1'b0)
			vout_level_in = d;
			repeat (2) @(negedge clk_in);
			`CHK(pg, 1'b1)
			vout_level_in = 16'h0000;
			go(1'b0, 16'h000A);
			wait_sig(2, 1'b1, 200);
			win(4 * CPM, 4 * CPM + 4);
			`CHK(pso, 1'b1)
			wait_sig(0, 1'b0, 200);
			win(CPM - 1, CPM + 3);
		end
		self_start_in = 1'b1;
		i_host.set_ton(16'h012C, 1'b1);
		go(1'b1, 16'h000A);
		wait_sig(0, 1'b1, 1400);
		win(300 * CPM, 300 * CPM + 4);
		clean();
		group_mode_in = 1'b0;
		self_start_in = 1'b0;
		i_host.set_ton(16'h0001, 1'b0);
		acc(1'b1, CMD_TURN_OFF_WAIT_TIME, 16'h0000, 1'b0);
		bring_on();
		go(1'b0, 16'h000A);
		wait_sig(0, 1'b0, 10);
		win(0, 2);
		`CHK(rdn, 1'b0)
		acc(1'b1, CMD_TURN_OFF_WAIT_TIME, RST_TURN_OFF_WAIT_TIME, 1'b0);
		for (int m = 0; m < 2; m++) begin
			acc(1'b1, CMD_UV_RESP, {8'h00, 2'(m), 6'h00}, 1'b0);
			bring_on();
			go(1'b1, 16'h0005);
			go(1'b1, 16'h000A);
			repeat (2) @(negedge clk_in);
			`CHK(alert_n, 1'b0)
			`CHK(pso, 1'b1)
			acc(1'b0, CMD_STATUS_BYTE, 16'h0008, 1'b0);
			clean();
		end
		d = 16'($urandom_range(0, 7));
		acc(1'b1, CMD_UV_RESP, {8'h00, 2'b10, 3'd2, d[2:0]}, 1'b0);
		bring_on();
		go(1'b1, 16'h0005);
		go(1'b1, 16'h000A);
		wait_sig(0, 1'b0, 4);
		`CHK(pso, 1'b0)
		`CHK(alert_n, 1'b0)
		wait_sig(0, 1'b1, 2500);
		r = (int'(d[2:0]) + 1) * 35 * CPM + 3 * CPM;
		win(r - 3, r + 6);
		clean();
		foreach (RC[i]) begin
			acc(1'b1, CMD_UV_RESP, {8'h00, 2'b10, RC[i], 3'h0}, 1'b0);
			bring_on();
			go(1'b1, 16'h0005);
			repeat (3 * 35 * CPM + 20) @(negedge clk_in);
			`CHK(pso, 1'b0)
			go(1'b1, 16'h000A);
			wait_sig(0, 1'b1, 38 * CPM + 10);
			`CHK(pso, RC[i] == 3'h7)
			if (RC[i] == 3'h0) begin
				acc(1'b1, CMD_CLEAR_FAULTS, 16'h0000, 1'b0);
				wait_sig(0, 1'b1, 3 * CPM + 8);
				`CHK(pso, 1'b1)
			end
			clean();
		end
		acc(1'b1, CMD_UV_RESP, {8'h00, RST_UV_RESP}, 1'b0);
		bring_on();
		go(1'b1, 16'h0005);
		go(1'b1, 16'h0008);
		repeat (100) @(negedge clk_in);
		`CHK(pso, 1'b0)
		go(1'b1, 16'h0009);
		wait_sig(0, 1'b1, 3 * CPM + 8);
		`CHK(pso, 1'b1)
		clean();
		acc(1'b1, CMD_UV_WARN, 16'h0009, 1'b0);
		bring_on();
		go(1'b1, 16'h0008);
		repeat (2) @(negedge clk_in);
		acc(1'b0, CMD_STATUS_INPUT, 16'h0020, 1'b0);
		go(1'b1, 16'h000A);
		acc(1'b1, CMD_CLEAR_FAULTS, 16'h0000, 1'b0);
		go(1'b1, 16'h000F);
		repeat (2) @(negedge clk_in);
		acc(1'b0, CMD_STATUS_INPUT, 16'h0040, 1'b0);
		acc(1'b0, CMD_STATUS_WORD, 16'h2800, 1'b0);
		`CHK(pso, 1'b1)
		`CHK(alert_n, 1'b1)
		clean();
		complete_run();
	end
endmodule
